// ---- logic/phase_channel.sv ----
// One phase output with asynchronous comparator termination
`timescale 1ns/100ps
`default_nettype none

module phase_channel (
	input wire logic clk,
	input wire logic srst,
	phase_link_if.chan link
);

	// ****************************************************************
	// Holdoff window and asynchronous stop
	// ****************************************************************
	pwm_pkg::chan_state_t st;
	pwm_pkg::chan_state_t next_st;
	logic q;
	logic holdoff;
	logic kill;

	// Blank the whole setting cycle, so the edge never meets an open kill,
	// then the high half after it: Tosc/2 of guaranteed active time
	always_comb begin
		holdoff = link.holdoff_en & (link.set | (st.fresh & clk));
	end

	// No stop enable set means no termination: full duty
	always_comb begin
		kill = |(link.cmp & link.stop_en) & ~holdoff;
	end

	always_comb begin
		next_st = st;
		next_st.fresh = link.set & link.enable & ~srst;
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	// Async clear by comparator; a glitch on an enabled cmp outside holdoff ends the pulse at once
	always_ff @(posedge clk or posedge kill) begin
		if (kill) begin
			q <= 1'b0;
		end else if (srst | ~link.enable) begin
			q <= 1'b0;
		end else if (link.set) begin
			q <= 1'b1;
		end
	end

	assign link.q = q;

endmodule

`default_nettype wire

// ---- logic/phase_link_if.sv ----
// Signals between the PWM timebase and one phase channel
`timescale 1ns/100ps
`default_nettype none

interface phase_link_if;
	logic set;
	logic enable;
	logic holdoff_en;
	logic [1:0] stop_en;
	logic [1:0] cmp;
	logic q;

	modport ctl (
		output set,
		output enable,
		output holdoff_en,
		output stop_en,
		output cmp,
		input q
	);

	modport chan (
		input set,
		input enable,
		input holdoff_en,
		input stop_en,
		input cmp,
		output q
	);
endinterface

`default_nettype wire

// ---- logic/pwm_map.svh ----
// Register offsets, field positions and reset values of the PWM block
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADDR_CTRL 5'h00
`define ADDR_TIMEBASE 5'h04
`define ADDR_PHASE_A 5'h08
`define ADDR_PHASE_B 5'h0c
`define ADDR_STATUS 5'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_PHASE_A_EN 0
`define CTRL_PHASE_B_EN 1
`define CTRL_ROLE_LO 2
`define CTRL_ROLE_HI 3
`define CTRL_HOLDOFF_A 4
`define CTRL_HOLDOFF_B 5
`define CTRL_WIDTH 6

// ****************************************************************
// Timebase register fields
// ****************************************************************
`define TB_PERIOD_LO 0
`define TB_PERIOD_HI 4
`define TB_DIV_LO 5
`define TB_DIV_HI 6

// ****************************************************************
// Phase register fields
// ****************************************************************
`define PH_OFFSET_LO 0
`define PH_OFFSET_HI 4
`define PH_STOP_CMP1 5
`define PH_STOP_CMP2 6
`define PH_WIDTH 7

// ****************************************************************
// Status register fields
// ****************************************************************
`define ST_COUNT_LO 0
`define ST_COUNT_HI 4
`define ST_SYNCED 5
`define ST_PHASE_A 6
`define ST_PHASE_B 7
`define ST_SYNC_OUT 8

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CTRL 6'h00
`define RST_PERIOD 5'h00
`define RST_DIV 2'h0
`define RST_PHASE 7'h00
`define RST_WAITREQ 1'h1
`define RST_RDATA 32'h0000_0000

`endif

// ---- logic/pwm_pkg.sv ----
// Types shared by the PWM block
package pwm_pkg;

	typedef enum logic [1:0] {
		ROLE_SELF_0 = 2'b00,
		ROLE_SELF_1 = 2'b01,
		ROLE_SLAVE = 2'b10,
		ROLE_MASTER = 2'b11
	} sync_role_t;

	typedef struct packed {
		logic [2:0] div_cnt;
		logic [4:0] count;
		logic synced;
		logic sync_out;
		logic sync_oe;
		logic waitreq;
		logic [31:0] rdata;
		logic [5:0] ctrl;
		logic [4:0] period;
		logic [1:0] div_sel;
		logic [6:0] ph_a;
		logic [6:0] ph_b;
	} pwm_state_t;

	typedef struct packed {
		logic fresh;
	} chan_state_t;

endpackage

// ---- logic/two_phase_feedback_pwm.sv ----
// Two-phase feedback PWM with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
`include "pwm_map.svh"

module two_phase_feedback_pwm (
	input wire logic clk,
	input wire logic srst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic cmp1_out,
	input wire logic cmp2_out,
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe,
	output logic phase_a_output,
	output logic phase_b_output
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Last value of the prescale counter for a divider select
	function automatic logic [2:0] div_last(input logic [1:0] sel);
		logic [2:0] r;
		r = 3'h0;
		unique case (sel)
			2'b00: begin
				r = 3'h0;
			end
			2'b01: begin
				r = 3'h1;
			end
			2'b10: begin
				r = 3'h3;
			end
			2'b11: begin
				r = 3'h7;
			end
		endcase
		return r;
	endfunction

	// Counter step with wrap at the period setting
	function automatic logic [4:0] count_step(
		input logic [4:0] cnt,
		input logic [4:0] per
	);
		logic [4:0] r;
		r = (cnt >= per) ? 5'h00 : 5'(cnt + 5'h01);
		return r;
	endfunction

	// Phase register view: the two stop enables, CMP2 above CMP1
	function automatic logic [1:0] stops(input logic [6:0] ph);
		return {ph[`PH_STOP_CMP2], ph[`PH_STOP_CMP1]};
	endfunction

	// Offset match for one phase register
	function automatic logic offset_hit(
		input logic [4:0] cnt,
		input logic [6:0] ph
	);
		return cnt == ph[`PH_OFFSET_HI:`PH_OFFSET_LO];
	endfunction

	// Decoded register hit on the bus address
	function automatic logic reg_hit(
		input logic [4:0] addr,
		input logic [4:0] target
	);
		return addr == target;
	endfunction

	// State after reset: bus idle with waitrequest up, settings clear
	function automatic pwm_pkg::pwm_state_t reset_state();
		pwm_pkg::pwm_state_t r;
		r.div_cnt = 3'h0;
		r.count = 5'h00;
		r.synced = 1'b0;
		r.sync_out = 1'b0;
		r.sync_oe = 1'b0;
		r.waitreq = `RST_WAITREQ;
		r.rdata = `RST_RDATA;
		r.ctrl = `RST_CTRL;
		r.period = `RST_PERIOD;
		r.div_sel = `RST_DIV;
		r.ph_a = `RST_PHASE;
		r.ph_b = `RST_PHASE;
		return r;
	endfunction

	// Status view: counter, sync state, both phases and the sync pin
	function automatic logic [31:0] status_of(
		input pwm_pkg::pwm_state_t s,
		input logic qa,
		input logic qb
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`ST_COUNT_HI:`ST_COUNT_LO] = s.count;
		w[`ST_SYNCED] = s.synced;
		w[`ST_PHASE_A] = qa;
		w[`ST_PHASE_B] = qb;
		w[`ST_SYNC_OUT] = s.sync_out;
		return w;
	endfunction

	// Prescale counter: cleared while idle and at every tick
	function automatic logic [2:0] prescale_next(
		input logic [2:0] cnt,
		input logic run,
		input logic tk
	);
		logic [2:0] r;
		r = 3'(cnt + 3'h1);
		if (!run || tk) begin
			r = 3'h0;
		end
		return r;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	pwm_pkg::pwm_state_t st;
	pwm_pkg::pwm_state_t next_st;
	pwm_pkg::sync_role_t role;
	logic running;
	logic tick;
	logic advanced;
	logic access;
	logic commit;
	logic [31:0] rd_value;
	logic [31:0] status_word;
	logic wr_ctrl;
	logic wr_timebase;
	logic wr_phase_a;
	logic wr_phase_b;

	phase_link_if link_a ();
	phase_link_if link_b ();

	always_comb begin
		role = pwm_pkg::sync_role_t'(st.ctrl[`CTRL_ROLE_HI:`CTRL_ROLE_LO]);
		running = st.ctrl[`CTRL_PHASE_A_EN] | st.ctrl[`CTRL_PHASE_B_EN];
		tick = running & (st.div_cnt == div_last(st.div_sel));
	end

	// ****************************************************************
	// Bus slave decode
	// ****************************************************************

	// One wait state on every access keeps read data from a flop
	always_comb begin
		access = (avs_read | avs_write) & st.waitreq;
		commit = avs_write & ~st.waitreq & avs_byteenable[0];
	end

	// Per-register write strobes; byte lane 0 carries every field
	always_comb begin
		wr_ctrl = commit & reg_hit(avs_address, `ADDR_CTRL);
		wr_timebase = commit & reg_hit(avs_address, `ADDR_TIMEBASE);
		wr_phase_a = commit & reg_hit(avs_address, `ADDR_PHASE_A);
		wr_phase_b = commit & reg_hit(avs_address, `ADDR_PHASE_B);
	end

	// ****************************************************************
	// Register readback
	// ****************************************************************
	always_comb begin
		status_word = status_of(st, link_a.q, link_b.q);
	end

	// Unmapped addresses read as zero and ignore writes
	always_comb begin
		rd_value = 32'h0000_0000;
		unique case (avs_address)
			`ADDR_CTRL: begin
				rd_value[5:0] = st.ctrl;
			end
			`ADDR_TIMEBASE: begin
				rd_value[6:0] = {st.div_sel, st.period};
			end
			`ADDR_PHASE_A: begin
				rd_value[6:0] = st.ph_a;
			end
			`ADDR_PHASE_B: begin
				rd_value[6:0] = st.ph_b;
			end
			`ADDR_STATUS: begin
				rd_value = status_word;
			end
			default: begin
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		advanced = 1'b0;

		// Bus handshake
		next_st.waitreq = ~access;
		if (access && avs_read) begin
			next_st.rdata = rd_value;
		end
		if (wr_ctrl) begin
			next_st.ctrl = avs_writedata[`CTRL_WIDTH-1:0];
		end
		if (wr_timebase) begin
			next_st.period = avs_writedata[`TB_PERIOD_HI:`TB_PERIOD_LO];
			next_st.div_sel = avs_writedata[`TB_DIV_HI:`TB_DIV_LO];
		end
		if (wr_phase_a) begin
			next_st.ph_a = avs_writedata[`PH_WIDTH-1:0];
		end
		if (wr_phase_b) begin
			next_st.ph_b = avs_writedata[`PH_WIDTH-1:0];
		end

		// Prescaler
		next_st.div_cnt = prescale_next(st.div_cnt, running, tick);

		// Period counter and sync
		if (!running) begin
			next_st.count = 5'h00;
			next_st.synced = 1'b0;
		end else if (tick) begin
			unique case (role)
				pwm_pkg::ROLE_SLAVE: begin
					if (sync_in) begin
						next_st.count = 5'h00;
						next_st.synced = 1'b1;
						advanced = 1'b1;
					end else if (st.synced) begin
						// Own wrap only as a guard; master sync normally wins
						next_st.count = count_step(st.count, st.period);
						advanced = 1'b1;
					end else begin
						next_st.count = 5'h00;
					end
				end
				default: begin
					next_st.count = count_step(st.count, st.period);
					next_st.synced = 1'b1;
					advanced = 1'b1;
				end
			endcase
		end

		if (role != pwm_pkg::ROLE_SLAVE && running) begin
			next_st.synced = 1'b1;
		end

		// Master pin drive; high through the final tick of each period
		next_st.sync_oe = (role == pwm_pkg::ROLE_MASTER);
		next_st.sync_out = (role == pwm_pkg::ROLE_MASTER) & running &
			(next_st.count == st.period);

		if (srst) begin
			next_st = reset_state();
			advanced = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	// ****************************************************************
	// Phase channels
	// ****************************************************************

	// ****************************************************************
	// Phase A link
	// ****************************************************************
	// Set on the edge the counter enters the offset: step is 360/(per+1)
	assign link_a.set = advanced & st.ctrl[`CTRL_PHASE_A_EN] &
		offset_hit(next_st.count, st.ph_a);
	assign link_a.enable = st.ctrl[`CTRL_PHASE_A_EN];
	assign link_a.holdoff_en = st.ctrl[`CTRL_HOLDOFF_A];
	assign link_a.stop_en = stops(st.ph_a);
	assign link_a.cmp = {cmp2_out, cmp1_out};

	// ****************************************************************
	// Phase B link
	// ****************************************************************
	assign link_b.set = advanced & st.ctrl[`CTRL_PHASE_B_EN] &
		offset_hit(next_st.count, st.ph_b);
	assign link_b.enable = st.ctrl[`CTRL_PHASE_B_EN];
	assign link_b.holdoff_en = st.ctrl[`CTRL_HOLDOFF_B];
	assign link_b.stop_en = stops(st.ph_b);
	assign link_b.cmp = {cmp2_out, cmp1_out};

	// ****************************************************************
	// Channel instances
	// ****************************************************************
	phase_channel u_phase_a (
		.clk(clk),
		.srst(srst),
		.link(link_a.chan)
	);

	phase_channel u_phase_b (
		.clk(clk),
		.srst(srst),
		.link(link_b.chan)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.waitreq;
	assign sync_out = st.sync_out;
	assign sync_oe = st.sync_oe;
	assign phase_a_output = link_a.q;
	assign phase_b_output = link_b.q;

endmodule

`default_nettype wire

// ---- tb/pwm_far_side.sv ----
// Comparator and sync master model beside the PWM block
`timescale 1ns/100ps
`default_nettype none

module pwm_far_side (
	input wire logic clk,
	input wire logic phase_a_output,
	input wire logic phase_b_output,
	input wire logic [3:0] trip,
	input wire logic sync_run,
	input wire logic [4:0] sync_per,
	output logic cmp1_out,
	output logic cmp2_out,
	output logic sync_pulse
);
	logic [3:0] age_a = 4'h0;
	logic [3:0] age_b = 4'h0;
	logic [4:0] sc = 5'h00;
	// Sense stays up one clock after drive ends, like decaying current
	always @(posedge clk) begin
		// Phase pins taken as driven outputs: direction bits cleared
		age_a <= phase_a_output ? age_a + 4'h1 : 4'h0;
		age_b <= phase_b_output ? age_b + 4'h1 : 4'h0;
		sc <= (sc == sync_per) ? 5'h00 : sc + 5'h01;
	end
	assign cmp1_out = age_a >= trip;
	assign cmp2_out = age_b >= trip;
	// Master period kept at or below the slave's
	assign sync_pulse = sync_run && sc == sync_per;
endmodule

`default_nettype wire

// ---- tb/two_phase_feedback_pwm_chk.sv ----
// Port-level assertions for the two-phase PWM block
`timescale 1ns/100ps
`default_nettype none
`include "pwm_map.svh"

module two_phase_feedback_pwm_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic cmp1_out,
	input wire logic cmp2_out,
	input wire logic sync_oe,
	input wire logic phase_a_output,
	input wire logic phase_b_output
);
	// ********
	// Settings shadow
	// ********
	logic [5:0] sh_ctrl;
	logic [6:0] sh_pa;
	logic [6:0] sh_pb;
	logic wr_ok;
	assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	// Taken at the commit edge so it lines up with the design's copy
	always_ff @(posedge clk) begin
		if (srst) begin
			sh_ctrl <= 6'h00;
			sh_pa <= 7'h00;
			sh_pb <= 7'h00;
		end else if (wr_ok) begin
			case (avs_address)
				`ADDR_CTRL: sh_ctrl <= avs_writedata[5:0];
				`ADDR_PHASE_A: sh_pa <= avs_writedata[6:0];
				`ADDR_PHASE_B: sh_pb <= avs_writedata[6:0];
				default: ;
			endcase
		end
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait low too long");
	property p_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("no bus answer");
	property p_reset;
		$fell(srst) |-> !phase_a_output && !phase_b_output && !sync_oe;
	endproperty
	a_reset: assert property (p_reset) else $error("active after reset");
	property p_idle_a;
		$stable(sh_ctrl[0]) && !sh_ctrl[0] |-> !phase_a_output;
	endproperty
	a_idle_a: assert property (p_idle_a) else $error("disabled A active");
	property p_stop_a;
		sh_pa[5] && cmp1_out && !sh_ctrl[4] |-> !phase_a_output;
	endproperty
	a_stop_a: assert property (p_stop_a) else $error("A not ended");
	property p_stop_b;
		sh_pb[6] && cmp2_out && !sh_ctrl[5] |-> !phase_b_output;
	endproperty
	a_stop_b: assert property (p_stop_b) else $error("B not ended");
	property p_full;
		phase_a_output && sh_ctrl[0] && sh_pa[6:5] == 2'h0
			|=> phase_a_output || !sh_ctrl[0] || sh_pa[6:5] != 2'h0;
	endproperty
	a_full: assert property (p_full) else $error("full duty broken");
	property p_role;
		$stable(sh_ctrl[3:2]) |-> sync_oe == (sh_ctrl[3:2] == 2'h3);
	endproperty
	a_role: assert property (p_role) else $error("sync enable wrong");
endmodule

bind two_phase_feedback_pwm two_phase_feedback_pwm_chk u_chk (.clk, .srst,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_waitrequest, .cmp1_out, .cmp2_out, .sync_oe, .phase_a_output,
	.phase_b_output);

`default_nettype wire

// ---- tb/two_phase_feedback_pwm_test.sv ----
// Self-checking bench for the two-phase PWM block
`timescale 1ns/100ps
`default_nettype none
`include "pwm_map.svh"

module two_phase_feedback_pwm_test;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, cmp1_out, cmp2_out, sync_in, sync_out, sync_oe;
	logic phase_a_output, phase_b_output, far_sync;
	logic [3:0] trip = 4'h2;
	logic sync_run = 1'b0;
	int num_errors = 0;
	int checks = 0;

	initial forever #12.5 clk = ~clk;
	// Shared sync pin: the design drives it only with its enable up
	assign sync_in = sync_oe ? sync_out : far_sync;

	two_phase_feedback_pwm u_dut (.clk, .srst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .cmp1_out, .cmp2_out, .sync_in, .sync_out,
		.sync_oe, .phase_a_output, .phase_b_output);
	pwm_far_side u_far (.clk, .phase_a_output, .phase_b_output, .trip,
		.sync_run, .sync_per(5'h03), .cmp1_out, .cmp2_out,
		.sync_pulse(far_sync));

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask

	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	function automatic logic pick(input int s);
		return s == 0 ? sync_out : (s == 1 ? phase_a_output : phase_b_output);
	endfunction

	// Edges until the chosen output is seen rising
	task automatic rise(input int s, output int k);
		logic p, c;
		p = pick(s);
		for (k = 1; k < 400; k++) begin
			@(posedge clk);
			c = pick(s);
			if (c === 1'b1 && p === 1'b0) break;
			p = c;
		end
	endtask

	task automatic width(input int s, output int k);
		k = 0;
		while (pick(s) === 1'b1 && k < 400) begin
			@(posedge clk);
			k++;
		end
	endtask

	task automatic t_regs;
		bus(1'h0, `ADDR_STATUS, 32'h0, 4'hf);
		check("status after reset", 32'h0, rd);
		bus(1'h1, `ADDR_TIMEBASE, 32'h0000_0065, 4'hf);
		bus(1'h1, `ADDR_TIMEBASE, 32'h0000_001f, 4'h0);
		bus(1'h0, `ADDR_TIMEBASE, 32'h0, 4'hf);
		check("timebase", 32'h0000_0065, rd);
		bus(1'h0, 5'h14, 32'h0, 4'hf);
		check("unmapped", 32'h0, rd);
	endtask

	task automatic t_period;
		int k;
		bus(1'h1, `ADDR_CTRL, 32'h0000_000d, 4'hf);
		for (int dv = 0; dv < 4; dv++) begin
			bus(1'h1, `ADDR_TIMEBASE, 32'(dv * 32 + 3), 4'hf);
			rise(0, k);
			rise(0, k);
			check("sync period", 32'((1 << dv) * 4), 32'(k));
			width(0, k);
			check("sync width", 32'(1 << dv), 32'(k));
		end
	endtask

	task automatic t_phase;
		int k;
		bus(1'h1, `ADDR_TIMEBASE, 32'h0000_0007, 4'hf);
		bus(1'h1, `ADDR_PHASE_A, 32'h0000_0064, 4'hf);
		bus(1'h1, `ADDR_PHASE_B, 32'h0000_0040, 4'hf);
		bus(1'h1, `ADDR_CTRL, 32'h0000_000f, 4'hf);
		rise(0, k);
		rise(1, k);
		check("phase a delay", 32'h5, 32'(k));
		width(1, k);
		check("phase a width", 32'h2, 32'(k));
		rise(0, k);
		rise(2, k);
		check("phase b delay", 32'h1, 32'(k));
		width(2, k);
		check("phase b width", 32'h2, 32'(k));
	endtask

	task automatic t_holdoff;
		int n;
		trip <= 4'h0;
		bus(1'h1, `ADDR_PHASE_A, 32'h0000_0020, 4'hf);
		bus(1'h1, `ADDR_CTRL, 32'h0000_0011, 4'hf);
		n = 0;
		while (phase_a_output !== 1'b1 && n < 40) begin
			@(posedge clk);
			#2;
			n++;
		end
		check("held off", 32'h1, phase_a_output);
		@(negedge clk);
		#2;
		check("ended after half", 32'h0, phase_a_output);
	endtask

	task automatic t_slave;
		int k;
		trip <= 4'h1;
		bus(1'h1, `ADDR_CTRL, 32'h0, 4'hf);
		bus(1'h1, `ADDR_TIMEBASE, 32'h0000_0007, 4'hf);
		bus(1'h1, `ADDR_PHASE_A, 32'h0000_0021, 4'hf);
		bus(1'h1, `ADDR_CTRL, 32'h0000_0009, 4'hf);
		repeat (20) @(posedge clk);
		bus(1'h0, `ADDR_STATUS, 32'h0, 4'hf);
		check("slave waits", 32'h0, rd);
		sync_run <= 1'b1;
		rise(1, k);
		rise(1, k);
		check("slave follows", 32'h4, 32'(k));
		sync_run <= 1'b0;
	endtask

	task automatic t_idle;
		bus(1'h1, `ADDR_PHASE_A, 32'h0, 4'hf);
		bus(1'h1, `ADDR_CTRL, 32'h0000_0001, 4'hf);
		repeat (12) @(posedge clk);
		check("full duty", 32'h1, phase_a_output);
		bus(1'h1, `ADDR_CTRL, 32'h0, 4'hf);
		repeat (6) @(posedge clk);
		bus(1'h0, `ADDR_STATUS, 32'h0, 4'hf);
		check("idle status", 32'h0, rd);
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_regs;
		t_period;
		t_phase;
		t_holdoff;
		t_slave;
		t_idle;
		stop_test;
	end

	// Whole run needs about three hundred clocks
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test;
	end
endmodule

`default_nettype wire
